// >>> cpu_status_ext_consts.svh
// offsets, field positions, reset values and timing counts of the status block
`ifndef CPU_STATUS_EXT_CONSTS_SVH
`define CPU_STATUS_EXT_CONSTS_SVH

// ----------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------
`define IDX_DATA_POINTER_LO 10'h082
`define IDX_DATA_POINTER_HI 10'h083
`define IDX_EXTENDED_OPERATION 10'h0a2
`define IDX_PROGRAM_STATUS_WORD 10'h0d0
`define IDX_ACCUMULATOR 10'h0e0
`define IDX_EEPROM_ADDR_LO 10'h140
`define IDX_EEPROM_ADDR_HI 10'h141
`define IDX_EEPROM_DATA 10'h142
`define IDX_BIT_ACCESS 10'h143

// ----------------------------------------
// field positions
// ----------------------------------------
`define PSW_CARRY_BIT 7
`define PSW_HALF_CARRY_BIT 6
`define PSW_USER_FLAG_ZERO_BIT 5
`define PSW_BANK_SELECT_HI_BIT 4
`define PSW_BANK_SELECT_LO_BIT 3
`define PSW_OVERFLOW_BIT 2
`define PSW_USER_FLAG_ONE_BIT 1
`define PSW_PARITY_BIT 0
`define XOP_TRAP_BIT 4
`define XOP_WRITABLE_MASK 8'h17
`define BIT_ACCESS_VALUE_BIT 8

// ----------------------------------------
// reset values and sizes
// ----------------------------------------
`define PSW_RESET 8'h00
`define XOP_RESET 8'h00
`define ACC_RESET 8'h00
`define EEPROM_BYTES 512
`define POINTER_COUNT 8

// ----------------------------------------
// timing
// ----------------------------------------
`define CLOCK_PERIOD_NS 25
`define INSTR_CYCLE_NS 300
`define INSTR_CYCLE_CLKS ((`INSTR_CYCLE_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

// ----------------------------------------
// bus answers
// ----------------------------------------
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// >>> cpu_status_ext_pkg.sv
// types shared by the status block files
package cpu_status_ext_pkg;

	// ----------------------------------------
	// bus slave states, gray on each step except ST_RD_RESP back to ST_IDLE
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RD_DATA = 2'b01,
		ST_RD_RESP = 2'b11,
		ST_WR_RESP = 2'b10
	} bus_state_e;

	// ----------------------------------------
	// register select
	// ----------------------------------------
	typedef enum logic [3:0] {
		SEL_NONE,
		SEL_PTR_LO,
		SEL_PTR_HI,
		SEL_EXT_OP,
		SEL_PSW,
		SEL_ACC,
		SEL_EE_ADDR_LO,
		SEL_EE_ADDR_HI,
		SEL_EE_DATA,
		SEL_BIT
	} reg_sel_e;

endpackage : cpu_status_ext_pkg

// >>> eeprom_byte_store.sv
// byte-wide data storage array with one write port and a registered read
`timescale 1ns/1ps
`include "cpu_status_ext_consts.svh"

module eeprom_byte_store (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// write port
	input wire logic i_we,
	input wire logic [8:0] i_addr,
	input wire logic [7:0] i_wdata,
	// read data, one cycle after the address
	output logic [7:0] o_rdata
);

	logic [7:0] mem [0:`EEPROM_BYTES-1];
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;

	assign o_rdata = rdata_reg;

	// ----------------------------------------
	// read path
	// ----------------------------------------
	always_comb begin
		rdata_next = mem[i_addr];
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// ----------------------------------------
	// storage, not reset: contents survive
	// ----------------------------------------
	// byte-wide write
	always_ff @(posedge i_clock) begin
		if (i_we) begin
			mem[i_addr] <= i_wdata;
		end
	end

endmodule : eeprom_byte_store

// >>> cpu_status_ext_regs.sv
// status word, extended-operation register, banked pointers and data storage access
`timescale 1ns/1ps
`include "cpu_status_ext_consts.svh"

// What this block does
// - 512 bytes of storage, separate from RAM, accessed byte-wise through registers
// - only the status word (D0) and accumulator (E0) indices are bit-addressable
// - status word at D0, reset 00, carry down to parity, bits 7..1 read-write, parity rewritten by hardware each instruction cycle
// - parity bit refreshed each instruction cycle from accumulator odd parity
// - status bits 4 and 3 form bank select, bit 4 upper
// - bank select picks one of four eight-register groups in lowest 32 bytes
// - extended-operation at A2, reset 00, bit 4 and bits 2..0 writable
// - trap select 0 makes special opcode a post-incrementing pointer move
// - trap select 1 makes the special opcode a software trap
// - pointer bank select 0..7 picks active sixteen-bit data pointer
module cpu_status_ext_regs (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// axi4-lite write address and data
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [11:0] i_s_axi_awaddr,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	// axi4-lite write response
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	output logic [1:0] o_s_axi_bresp,
	// axi4-lite read
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	input wire logic [11:0] i_s_axi_araddr,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	// core side
	input wire logic i_special_op,
	input wire logic i_acc_we,
	input wire logic [7:0] i_acc_wdata,
	output logic [4:0] o_bank_base,
	output logic [15:0] o_active_pointer,
	output logic o_pointer_move,
	output logic [15:0] o_move_addr,
	output logic [7:0] o_move_data,
	output logic o_trap,
	output logic o_instr_tick
);

	// ----------------------------------------
	// decode
	// ----------------------------------------
	function automatic cpu_status_ext_pkg::reg_sel_e decode(input logic [9:0] idx);
		case (idx)
			`IDX_DATA_POINTER_LO: decode = cpu_status_ext_pkg::SEL_PTR_LO;
			`IDX_DATA_POINTER_HI: decode = cpu_status_ext_pkg::SEL_PTR_HI;
			`IDX_EXTENDED_OPERATION: decode = cpu_status_ext_pkg::SEL_EXT_OP;
			`IDX_PROGRAM_STATUS_WORD: decode = cpu_status_ext_pkg::SEL_PSW;
			`IDX_ACCUMULATOR: decode = cpu_status_ext_pkg::SEL_ACC;
			`IDX_EEPROM_ADDR_LO: decode = cpu_status_ext_pkg::SEL_EE_ADDR_LO;
			`IDX_EEPROM_ADDR_HI: decode = cpu_status_ext_pkg::SEL_EE_ADDR_HI;
			`IDX_EEPROM_DATA: decode = cpu_status_ext_pkg::SEL_EE_DATA;
			`IDX_BIT_ACCESS: decode = cpu_status_ext_pkg::SEL_BIT;
			default: decode = cpu_status_ext_pkg::SEL_NONE;
		endcase
	endfunction : decode

	// bit address: upper five bits name the byte, lower three the bit
	function automatic cpu_status_ext_pkg::reg_sel_e bit_target(input logic [7:0] baddr);
		bit_target = decode({2'b00, baddr[7:3], 3'b000});
		if (bit_target != cpu_status_ext_pkg::SEL_PSW && bit_target != cpu_status_ext_pkg::SEL_ACC) begin
			bit_target = cpu_status_ext_pkg::SEL_NONE;
		end
	endfunction : bit_target

	// ----------------------------------------
	// state
	// ----------------------------------------
	cpu_status_ext_pkg::bus_state_e state_reg, state_next;
	logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
	logic [9:0] aw_idx_reg, aw_idx_next, ar_idx_reg, ar_idx_next;
	logic [31:0] wdata_reg, wdata_next;
	logic wlane_reg, wlane_next;
	logic awready_reg, awready_next, wready_reg, wready_next, arready_reg, arready_next;
	logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [7:0] psw_reg, psw_next, xop_reg, xop_next, acc_reg, acc_next;
	logic [8:0] ee_addr_reg, ee_addr_next;
	logic [7:0] bit_addr_reg, bit_addr_next;
	logic [15:0] ptr_reg [0:`POINTER_COUNT-1];
	logic [15:0] ptr_next [0:`POINTER_COUNT-1];
	logic [3:0] tick_cnt_reg, tick_cnt_next;
	logic tick_reg, tick_next;
	logic move_reg, move_next, trap_reg, trap_next;
	logic [15:0] move_addr_reg, move_addr_next, active_reg, active_next;
	logic [7:0] move_data_reg, move_data_next;
	logic [4:0] bank_reg, bank_next;
	logic wr_fire;
	logic ee_we;
	logic [7:0] ee_q;
	logic [7:0] bit_byte;
	cpu_status_ext_pkg::reg_sel_e wsel, rsel, bsel;

	eeprom_byte_store eeprom_byte_store_inst (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_we(ee_we),
		.i_addr(ee_addr_reg),
		.i_wdata(wdata_reg[7:0]),
		.o_rdata(ee_q)
	);

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		aw_have_next = aw_have_reg;
		w_have_next = w_have_reg;
		aw_idx_next = aw_idx_reg;
		ar_idx_next = ar_idx_reg;
		wdata_next = wdata_reg;
		wlane_next = wlane_reg;
		bvalid_next = bvalid_reg;
		rvalid_next = rvalid_reg;
		bresp_next = bresp_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		wr_fire = 1'b0;
		wsel = decode(aw_idx_reg);
		rsel = decode(ar_idx_reg);
		if (i_s_axi_awvalid && awready_reg) begin
			aw_have_next = 1'b1;
			aw_idx_next = i_s_axi_awaddr[11:2];
		end
		if (i_s_axi_wvalid && wready_reg) begin
			w_have_next = 1'b1;
			wdata_next = i_s_axi_wdata;
			wlane_next = i_s_axi_wstrb[0];
		end
		case (state_reg)
			cpu_status_ext_pkg::ST_IDLE: begin
				if (aw_have_reg && w_have_reg) begin
					wr_fire = wlane_reg;
					aw_have_next = 1'b0;
					w_have_next = 1'b0;
					bvalid_next = 1'b1;
					bresp_next = (wsel == cpu_status_ext_pkg::SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
					state_next = cpu_status_ext_pkg::ST_WR_RESP;
				end else if (i_s_axi_arvalid && arready_reg) begin
					ar_idx_next = i_s_axi_araddr[11:2];
					state_next = cpu_status_ext_pkg::ST_RD_DATA;
				end
			end
			cpu_status_ext_pkg::ST_RD_DATA: begin
				rvalid_next = 1'b1;
				rresp_next = `RESP_OKAY;
				case (rsel)
					cpu_status_ext_pkg::SEL_PTR_LO: rdata_next = {24'h000000, active_reg[7:0]};
					cpu_status_ext_pkg::SEL_PTR_HI: rdata_next = {24'h000000, active_reg[15:8]};
					cpu_status_ext_pkg::SEL_EXT_OP: rdata_next = {24'h000000, xop_reg & `XOP_WRITABLE_MASK};
					cpu_status_ext_pkg::SEL_PSW: rdata_next = {24'h000000, psw_reg};
					cpu_status_ext_pkg::SEL_ACC: rdata_next = {24'h000000, acc_reg};
					cpu_status_ext_pkg::SEL_EE_ADDR_LO: rdata_next = {24'h000000, ee_addr_reg[7:0]};
					cpu_status_ext_pkg::SEL_EE_ADDR_HI: rdata_next = {31'h00000000, ee_addr_reg[8]};
					cpu_status_ext_pkg::SEL_EE_DATA: rdata_next = {24'h000000, ee_q};
					cpu_status_ext_pkg::SEL_BIT: rdata_next = {23'h000000, bit_byte[bit_addr_reg[2:0]], bit_addr_reg};
					default: begin
						rdata_next = 32'h00000000;
						rresp_next = `RESP_SLVERR;
					end
				endcase
				state_next = cpu_status_ext_pkg::ST_RD_RESP;
			end
			cpu_status_ext_pkg::ST_RD_RESP: begin
				if (i_s_axi_rready) begin
					rvalid_next = 1'b0;
					state_next = cpu_status_ext_pkg::ST_IDLE;
				end
			end
			cpu_status_ext_pkg::ST_WR_RESP: begin
				if (i_s_axi_bready) begin
					bvalid_next = 1'b0;
					state_next = cpu_status_ext_pkg::ST_IDLE;
				end
			end
			default: state_next = cpu_status_ext_pkg::ST_IDLE;
		endcase
		// a held address or data blocks its own channel until the write fires in idle
		awready_next = !aw_have_next;
		wready_next = !w_have_next;
		arready_next = (state_next == cpu_status_ext_pkg::ST_IDLE) && !(aw_have_next && w_have_next)
			&& !(i_s_axi_arvalid && arready_reg);
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			state_reg <= cpu_status_ext_pkg::ST_IDLE;
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			aw_idx_reg <= 10'h000;
			ar_idx_reg <= 10'h000;
			wdata_reg <= 32'h00000000;
			wlane_reg <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			arready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			bresp_reg <= `RESP_OKAY;
			rresp_reg <= `RESP_OKAY;
			rdata_reg <= 32'h00000000;
		end else begin
			state_reg <= state_next;
			aw_have_reg <= aw_have_next;
			w_have_reg <= w_have_next;
			aw_idx_reg <= aw_idx_next;
			ar_idx_reg <= ar_idx_next;
			wdata_reg <= wdata_next;
			wlane_reg <= wlane_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			arready_reg <= arready_next;
			bvalid_reg <= bvalid_next;
			rvalid_reg <= rvalid_next;
			bresp_reg <= bresp_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
		end
	end

	// ----------------------------------------
	// register file and core effects
	// ----------------------------------------
	assign bsel = bit_target(bit_addr_reg);
	assign bit_byte = (bsel == cpu_status_ext_pkg::SEL_PSW) ? psw_reg :
		(bsel == cpu_status_ext_pkg::SEL_ACC) ? acc_reg : 8'h00;
	assign ee_we = wr_fire && (wsel == cpu_status_ext_pkg::SEL_EE_DATA);

	always_comb begin
		psw_next = psw_reg;
		xop_next = xop_reg;
		acc_next = acc_reg;
		ee_addr_next = ee_addr_reg;
		bit_addr_next = bit_addr_reg;
		for (int i = 0; i < `POINTER_COUNT; i++) begin
			ptr_next[i] = ptr_reg[i];
		end
		if (i_acc_we) begin
			acc_next = i_acc_wdata;
		end
		if (wr_fire) begin
			case (wsel)
				cpu_status_ext_pkg::SEL_PTR_LO: ptr_next[xop_reg[2:0]][7:0] = wdata_reg[7:0];
				cpu_status_ext_pkg::SEL_PTR_HI: ptr_next[xop_reg[2:0]][15:8] = wdata_reg[7:0];
				cpu_status_ext_pkg::SEL_EXT_OP: xop_next = wdata_reg[7:0] & `XOP_WRITABLE_MASK;
				cpu_status_ext_pkg::SEL_PSW: psw_next = wdata_reg[7:0];
				cpu_status_ext_pkg::SEL_ACC: acc_next = wdata_reg[7:0];
				cpu_status_ext_pkg::SEL_EE_ADDR_LO: ee_addr_next[7:0] = wdata_reg[7:0];
				cpu_status_ext_pkg::SEL_EE_ADDR_HI: ee_addr_next[8] = wdata_reg[0];
				cpu_status_ext_pkg::SEL_BIT: begin
					bit_addr_next = wdata_reg[7:0];
					case (bit_target(wdata_reg[7:0]))
						cpu_status_ext_pkg::SEL_PSW:
							psw_next[wdata_reg[2:0]] = wdata_reg[`BIT_ACCESS_VALUE_BIT];
						cpu_status_ext_pkg::SEL_ACC:
							acc_next[wdata_reg[2:0]] = wdata_reg[`BIT_ACCESS_VALUE_BIT];
						default: bit_addr_next = wdata_reg[7:0];
					endcase
				end
				default: xop_next = xop_reg;
			endcase
		end
		if (i_special_op && !xop_reg[`XOP_TRAP_BIT]) begin
			ptr_next[xop_reg[2:0]] = ptr_next[xop_reg[2:0]] + 16'h0001;
		end
		// hardware parity wins over a write
		if (tick_reg) begin
			psw_next[`PSW_PARITY_BIT] = ^acc_reg;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			psw_reg <= `PSW_RESET;
			xop_reg <= `XOP_RESET;
			acc_reg <= `ACC_RESET;
			ee_addr_reg <= 9'h000;
			bit_addr_reg <= 8'h00;
			for (int i = 0; i < `POINTER_COUNT; i++) begin
				ptr_reg[i] <= 16'h0000;
			end
		end else begin
			psw_reg <= psw_next;
			xop_reg <= xop_next;
			acc_reg <= acc_next;
			ee_addr_reg <= ee_addr_next;
			bit_addr_reg <= bit_addr_next;
			for (int i = 0; i < `POINTER_COUNT; i++) begin
				ptr_reg[i] <= ptr_next[i];
			end
		end
	end

	// ----------------------------------------
	// instruction cycle and core outputs
	// ----------------------------------------
	always_comb begin
		tick_next = (tick_cnt_reg == 4'(`INSTR_CYCLE_CLKS - 1));
		tick_cnt_next = tick_next ? 4'h0 : tick_cnt_reg + 4'h1;
		// pointer move when trap select clear
		move_next = i_special_op && !xop_reg[`XOP_TRAP_BIT];
		trap_next = i_special_op && xop_reg[`XOP_TRAP_BIT];
		move_addr_next = move_next ? ptr_reg[xop_reg[2:0]] : move_addr_reg;
		move_data_next = move_next ? acc_reg : move_data_reg;
		active_next = ptr_next[xop_next[2:0]];
		bank_next = {psw_next[`PSW_BANK_SELECT_HI_BIT], psw_next[`PSW_BANK_SELECT_LO_BIT], 3'b000};
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			tick_cnt_reg <= 4'h0;
			tick_reg <= 1'b0;
			move_reg <= 1'b0;
			trap_reg <= 1'b0;
			move_addr_reg <= 16'h0000;
			move_data_reg <= 8'h00;
			active_reg <= 16'h0000;
			bank_reg <= 5'h00;
		end else begin
			tick_cnt_reg <= tick_cnt_next;
			tick_reg <= tick_next;
			move_reg <= move_next;
			trap_reg <= trap_next;
			move_addr_reg <= move_addr_next;
			move_data_reg <= move_data_next;
			active_reg <= active_next;
			bank_reg <= bank_next;
		end
	end

	assign o_s_axi_awready = awready_reg;
	assign o_s_axi_wready = wready_reg;
	assign o_s_axi_arready = arready_reg;
	assign o_s_axi_bvalid = bvalid_reg;
	assign o_s_axi_bresp = bresp_reg;
	assign o_s_axi_rvalid = rvalid_reg;
	assign o_s_axi_rdata = rdata_reg;
	assign o_s_axi_rresp = rresp_reg;
	assign o_bank_base = bank_reg;
	assign o_active_pointer = active_reg;
	assign o_pointer_move = move_reg;
	assign o_move_addr = move_addr_reg;
	assign o_move_data = move_data_reg;
	assign o_trap = trap_reg;
	assign o_instr_tick = tick_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	property p_parity;
		tick_reg |=> psw_reg[`PSW_PARITY_BIT] == ^$past(acc_reg);
	endproperty
	a_parity: assert property (p_parity) else $error("parity not refreshed");

	property p_xop_unused_zero;
		(xop_reg & ~`XOP_WRITABLE_MASK) == 8'h00;
	endproperty
	a_xop_unused_zero: assert property (p_xop_unused_zero) else $error("unused bits set");

	property p_bank;
		##1 bank_reg == {psw_reg[4:3], 3'b000};
	endproperty
	a_bank: assert property (p_bank) else $error("bank base wrong");

	property p_move;
		i_special_op && !xop_reg[`XOP_TRAP_BIT] |=> o_pointer_move && !o_trap
			&& o_move_addr == $past(ptr_reg[xop_reg[2:0]]);
	endproperty
	a_move: assert property (p_move) else $error("pointer move missing");

	property p_trap;
		i_special_op && xop_reg[`XOP_TRAP_BIT] |=> o_trap && !o_pointer_move;
	endproperty
	a_trap: assert property (p_trap) else $error("trap missing");

	property p_incr;
		i_special_op && !xop_reg[4] && !wr_fire |=> ptr_reg[$past(xop_reg[2:0])]
			== $past(ptr_reg[xop_reg[2:0]]) + 16'h0001;
	endproperty
	a_incr: assert property (p_incr) else $error("pointer not incremented");

	property p_psw_write;
		wr_fire && wsel == cpu_status_ext_pkg::SEL_PSW && !tick_reg |=> psw_reg == $past(wdata_reg[7:0]);
	endproperty
	a_psw_write: assert property (p_psw_write) else $error("status write lost");

	property p_xop_write;
		wr_fire && wsel == cpu_status_ext_pkg::SEL_EXT_OP
			|=> xop_reg == ($past(wdata_reg[7:0]) & `XOP_WRITABLE_MASK);
	endproperty
	a_xop_write: assert property (p_xop_write) else $error("ext op write wrong");

	// stored byte shows two cycles after the write cycle
	property p_ee_roundtrip;
		ee_we ##1 !ee_we [*2] |-> ee_q == $past(wdata_reg[7:0], 2) || ee_addr_reg != $past(ee_addr_reg, 2);
	endproperty
	a_ee_roundtrip: assert property (p_ee_roundtrip) else $error("storage byte lost");

	property p_bit_read;
		state_reg == cpu_status_ext_pkg::ST_RD_DATA && rsel == cpu_status_ext_pkg::SEL_BIT
			|=> o_s_axi_rvalid && o_s_axi_rdata[8] == $past(bit_byte[bit_addr_reg[2:0]]);
	endproperty
	a_bit_read: assert property (p_bit_read) else $error("bit read wrong");

	property p_rd_latency;
		i_s_axi_arvalid && o_s_axi_arready |-> ##2 o_s_axi_rvalid;
	endproperty
	a_rd_latency: assert property (p_rd_latency) else $error("read answer late");

	c_trap: cover property (i_special_op && xop_reg[4] ##1 o_trap);
	c_move: cover property (o_pointer_move ##[1:8] o_pointer_move);
	c_ee_read: cover property (rsel == cpu_status_ext_pkg::SEL_EE_DATA && o_s_axi_rvalid);

endmodule : cpu_status_ext_regs

// >>> cpu_status_ext_regs_tb.sv
// self-checking bench for the status and extended-operation block
`timescale 1ns/1ps
`include "cpu_status_ext_consts.svh"

module cpu_status_ext_regs_tb;
	localparam logic [9:0] ix_xop = `IDX_EXTENDED_OPERATION;
	localparam logic [9:0] ix_psw = `IDX_PROGRAM_STATUS_WORD;
	localparam logic [9:0] ix_acc = `IDX_ACCUMULATOR;
	localparam logic [9:0] ix_plo = `IDX_DATA_POINTER_LO;
	localparam logic [9:0] ix_phi = `IDX_DATA_POINTER_HI;
	localparam logic [9:0] ix_bit = `IDX_BIT_ACCESS;
	logic i_clock, i_rst_n, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready;
	logic i_s_axi_arvalid, i_s_axi_rready, i_special_op, i_acc_we;
	logic [11:0] i_s_axi_awaddr, i_s_axi_araddr;
	logic [31:0] i_s_axi_wdata, o_s_axi_rdata;
	logic [3:0] i_s_axi_wstrb;
	logic [7:0] i_acc_wdata, o_move_data;
	logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
	logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
	logic [4:0] o_bank_base;
	logic [15:0] o_active_pointer, o_move_addr;
	logic o_pointer_move, o_trap, o_instr_tick;
	logic [33:0] rd_q [$];
	logic [1:0] wr_q [$];
	int n_mismatch = 0;
	int total_checks = 0;
	int gap;
	logic [15:0] ptr [8];
	logic [7:0] psw_v, acc_v;
	logic [7:0] ee_v [3];
	logic [8:0] ee_a [3] = '{9'h000, 9'h1ff, 9'h0aa};

	cpu_status_ext_regs cpu_status_ext_regs_inst (.i_clock, .i_rst_n, .i_s_axi_awvalid,
		.o_s_axi_awready, .i_s_axi_awaddr, .i_s_axi_wvalid, .o_s_axi_wready, .i_s_axi_wdata,
		.i_s_axi_wstrb, .o_s_axi_bvalid, .i_s_axi_bready, .o_s_axi_bresp, .i_s_axi_arvalid,
		.o_s_axi_arready, .i_s_axi_araddr, .o_s_axi_rvalid, .i_s_axi_rready, .o_s_axi_rdata,
		.o_s_axi_rresp, .i_special_op, .i_acc_we, .i_acc_wdata, .o_bank_base, .o_active_pointer,
		.o_pointer_move, .o_move_addr, .o_move_data, .o_trap, .o_instr_tick);

	initial begin
		i_clock = 1'b0;
		forever #12.5 i_clock = ~i_clock;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [33:0] ok(input logic [7:0] d);
		return {`RESP_OKAY, 24'h0, d};
	endfunction : ok

	task automatic check(input logic [33:0] got, input logic [33:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic ticks(input int n);
		repeat (n) @(posedge i_clock);
	endtask : ticks

	// aw and w offered together, each dropped once taken
	task automatic wr(input logic [9:0] idx, input logic [31:0] d, input logic [3:0] s = 4'h1,
		input logic [1:0] r = `RESP_OKAY);
		logic aw_done, w_done;
		@(posedge i_clock);
		wr_q.push_back(r);
		i_s_axi_awaddr <= {idx, 2'b00};
		i_s_axi_wdata <= d;
		i_s_axi_wstrb <= s;
		i_s_axi_awvalid <= 1'b1;
		i_s_axi_wvalid <= 1'b1;
		i_s_axi_bready <= 1'b1;
		aw_done = 1'b0;
		w_done = 1'b0;
		while (!(aw_done && w_done)) begin
			@(posedge i_clock);
			if (i_s_axi_awvalid && o_s_axi_awready) begin
				aw_done = 1'b1;
				i_s_axi_awvalid <= 1'b0;
			end
			if (i_s_axi_wvalid && o_s_axi_wready) begin
				w_done = 1'b1;
				i_s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge i_clock); while (!o_s_axi_bvalid);
		i_s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [9:0] idx, input logic [33:0] e);
		@(posedge i_clock);
		rd_q.push_back(e);
		i_s_axi_araddr <= {idx, 2'b00};
		i_s_axi_arvalid <= 1'b1;
		i_s_axi_rready <= 1'b1;
		do @(posedge i_clock); while (!o_s_axi_arready);
		i_s_axi_arvalid <= 1'b0;
		do @(posedge i_clock); while (!o_s_axi_rvalid);
		i_s_axi_rready <= 1'b0;
	endtask : rd

	task automatic pulse_op;
		@(posedge i_clock);
		i_special_op <= 1'b1;
		@(posedge i_clock);
		i_special_op <= 1'b0;
		@(posedge i_clock);
	endtask : pulse_op

	task automatic ee_set(input logic [8:0] a);
		wr(`IDX_EEPROM_ADDR_LO, 32'(a[7:0]));
		wr(`IDX_EEPROM_ADDR_HI, 32'(a[8]));
	endtask : ee_set

	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : report_and_stop

	// ----------------------------------------
	// answer watcher, oldest note first
	// ----------------------------------------
	always @(posedge i_clock) begin
		if (o_s_axi_rvalid && i_s_axi_rready) begin
			if (rd_q.size() > 0) check({o_s_axi_rresp, o_s_axi_rdata}, rd_q.pop_front());
			else check(34'h0, 34'h1);
		end
		if (o_s_axi_bvalid && i_s_axi_bready) begin
			if (wr_q.size() > 0) check(34'(o_s_axi_bresp), 34'(wr_q.pop_front()));
			else check(34'h0, 34'h1);
		end
	end

	// hang guard, well past the expected run
	initial begin
		#(25 * 40000);
		n_mismatch++;
		report_and_stop();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{i_rst_n, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} = '0;
		{i_s_axi_arvalid, i_s_axi_rready, i_special_op, i_acc_we} = '0;
		{i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata, i_s_axi_wstrb, i_acc_wdata} = '0;
		void'($urandom(32'ha4c6));
		repeat (3) @(posedge i_clock);
		i_rst_n <= 1'b1;
		ticks(2);
		rd(ix_psw, ok(8'h00));
		rd(ix_xop, ok(8'h00));
		wr(ix_xop, 32'hff);
		rd(ix_xop, ok(8'h17));
		wr(ix_xop, 32'h00, 4'h0);
		rd(ix_xop, ok(8'h17));
		do @(posedge i_clock); while (!o_instr_tick);
		gap = 0;
		do begin @(posedge i_clock); gap++; end while (!o_instr_tick && gap < 50);
		check(34'(gap), 34'd12);
		for (int i = 0; i < 4; i++) begin
			acc_v = 8'($urandom);
			psw_v = {3'($urandom), 2'(i), 3'($urandom)};
			wr(ix_acc, 32'(acc_v));
			wr(ix_psw, 32'(psw_v));
			ticks(14);
			rd(ix_psw, ok({psw_v[7:1], ^acc_v}));
			rd(ix_acc, ok(acc_v));
			check(34'(o_bank_base), 34'({2'(i), 3'b000}));
		end
		for (int i = 0; i < 3; i++) begin
			@(posedge i_clock);
			acc_v = 8'($urandom);
			i_acc_we <= 1'b1;
			i_acc_wdata <= acc_v;
			@(posedge i_clock);
			i_acc_we <= 1'b0;
			ticks(14);
			rd(ix_acc, ok(acc_v));
			rd(ix_psw, ok({psw_v[7:1], ^acc_v}));
		end
		wr(ix_bit, 32'h1d5);
		rd(ix_psw, ok({psw_v[7:6], 1'b1, psw_v[4:1], ^acc_v}));
		rd(ix_bit, {`RESP_OKAY, 32'h1d5});
		wr(ix_bit, 32'h0d5);
		rd(ix_psw, ok({psw_v[7:6], 1'b0, psw_v[4:1], ^acc_v}));
		wr(ix_bit, 32'h1e7);
		acc_v[7] = 1'b1;
		rd(ix_acc, ok(acc_v));
		for (int s = 0; s < 8; s++) begin
			ptr[s] = (s == 7) ? {8'($urandom), 8'hff} : 16'($urandom);
			wr(ix_xop, 32'(s));
			wr(ix_plo, 32'(ptr[s][7:0]));
			wr(ix_phi, 32'(ptr[s][15:8]));
		end
		for (int s = 0; s < 8; s++) begin
			wr(ix_xop, 32'(s));
			ticks(3);
			check(34'(o_active_pointer), 34'(ptr[s]));
			rd(ix_plo, ok(ptr[s][7:0]));
			rd(ix_phi, ok(ptr[s][15:8]));
		end
		// move with carry into high byte
		pulse_op();
		check(34'({o_pointer_move, o_trap, o_move_addr, o_move_data}),
			34'({2'b10, ptr[7], acc_v}));
		rd(ix_plo, ok(8'h00));
		rd(ix_phi, ok(ptr[7][15:8] + 8'h01));
		wr(ix_xop, 32'h17);
		pulse_op();
		check(34'({o_pointer_move, o_trap}), 34'h1);
		rd(ix_plo, ok(8'h00));
		for (int k = 0; k < 3; k++) begin
			ee_v[k] = 8'($urandom);
			ee_set(ee_a[k]);
			wr(`IDX_EEPROM_DATA, 32'(ee_v[k]));
		end
		for (int k = 0; k < 3; k++) begin
			ee_set(ee_a[k]);
			rd(`IDX_EEPROM_DATA, ok(ee_v[k]));
		end
		rd(10'h0a3, {`RESP_SLVERR, 32'h0});
		wr(10'h0a3, 32'h5a, 4'h1, `RESP_SLVERR);
		ticks(4);
		report_and_stop();
	end
endmodule : cpu_status_ext_regs_tb
